// *** verilog/oag_core.sv ***
// operand address generator top
`timescale 1ns/10ps
`default_nettype none
module oag_core #(
  parameter bit RF_LARGE = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // instruction start
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] stack_pointer_reg_i,
  // memory bus
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  // results
  output logic done_o,
  output logic bad_op_o,
  output logic [15:0] src_addr_o,
  output logic [15:0] dst_addr_o,
  output logic [7:0] imm_o,
  output logic imm_valid_o,
  output logic pc_load_o,
  output logic [15:0] new_pc_o,
  output logic [15:0] next_instruction_address_o,
  output logic [1:0] rf_cycles_o,
  output logic rf_range_err_o,
  output logic [3:0] mode_o
);
  typedef struct packed {
    oag_pkg::oag_state_t st;
    logic [15:0] pc;
    logic [7:0] op;
    logic pre;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] cnt;
    logic [7:0] pl;
    logic [7:0] ph;
    logic [7:0] regb;
    logic [7:0] sp;
    logic rd;
    logic [15:0] maddr;
    logic done;
    logic bad;
    logic [15:0] src;
    logic [15:0] dst;
    logic [7:0] imm;
    logic immv;
    logic pcl;
    logic [15:0] npc;
    logic [15:0] nia;
    logic [1:0] rfc;
    logic rferr;
    logic [3:0] mode;
  } oag_core_t;

  oag_core_t cur_ff;
  oag_core_t nxt_ff;
  oag_pkg::oag_mode_t dmode;
  oag_pkg::oag_class_t dcls;
  logic [1:0] dnb;
  logic dsta;
  logic dstb;
  logic [15:0] sum;
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic [15:0] add_c;
  logic [15:0] nia;
  logic [7:0] pair_lo_ad;

  oag_decode u_dec (
    .op_i(cur_ff.op),
    .prefixed_i(cur_ff.pre),
    .mode_o(dmode),
    .cls_o(dcls),
    .nbytes_o(dnb),
    .dst_a_o(dsta),
    .dst_b_o(dstb)
  );

  oag_adder #(.WIDTH(16)) u_add (
    .a_i(add_a),
    .b_i(add_b),
    .c_i(add_c),
    .sum_o(sum)
  );

  // next instruction address and pointer byte
  assign nia = 16'(cur_ff.pc + 16'(cur_ff.pre) + 16'(dnb) + 16'h0001);
  assign pair_lo_ad = (dmode == oag_pkg::OAG_M_ABS_OFF ||
    dmode == oag_pkg::OAG_M_REL_OFF) ? cur_ff.b2 : cur_ff.b1;

  // adder operand select per mode
  always_comb begin
    add_a = 16'h0000;
    add_b = 16'h0000;
    add_c = 16'h0000;
    case (dmode)
      oag_pkg::OAG_M_SPREL: begin
        add_a = {8'h00, cur_ff.sp};
        add_b = {8'h00, cur_ff.b1};
      end
      oag_pkg::OAG_M_PCREL: begin
        add_a = nia;
        add_b = {{8{cur_ff.b1[7]}}, cur_ff.b1};
      end
      oag_pkg::OAG_M_ABS_IDX: begin
        add_a = {cur_ff.b1, cur_ff.b2};
        add_b = {8'h00, cur_ff.regb};
      end
      oag_pkg::OAG_M_REL_DIR: begin
        add_a = {cur_ff.b1, cur_ff.b2};
        add_b = nia;
      end
      oag_pkg::OAG_M_REL_IDX: begin
        add_a = {cur_ff.b1, cur_ff.b2};
        add_b = {8'h00, cur_ff.regb};
        add_c = nia;
      end
      oag_pkg::OAG_M_ABS_IND: add_a = {cur_ff.ph, cur_ff.pl};
      oag_pkg::OAG_M_REL_IND: begin
        add_a = {cur_ff.ph, cur_ff.pl};
        add_b = nia;
      end
      oag_pkg::OAG_M_ABS_OFF: begin
        add_a = {cur_ff.ph, cur_ff.pl};
        add_b = {{8{cur_ff.b1[7]}}, cur_ff.b1};
      end
      oag_pkg::OAG_M_REL_OFF: begin
        add_a = {cur_ff.ph, cur_ff.pl};
        add_b = {{8{cur_ff.b1[7]}}, cur_ff.b1};
        add_c = nia;
      end
      default: add_a = 16'h0000;
    endcase
  end

  // sequencer and result formation
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    nxt_ff.rd = 1'b0;
    case (cur_ff.st)
      oag_pkg::OAG_S_IDLE: begin
        if (start_i) begin
          nxt_ff.pc = pc_i;
          nxt_ff.sp = stack_pointer_reg_i;
          nxt_ff.pre = 1'b0;
          nxt_ff.cnt = 2'h0;
          nxt_ff.rd = 1'b1;
          nxt_ff.maddr = pc_i;
          nxt_ff.st = oag_pkg::OAG_S_OP1;
        end
      end
      oag_pkg::OAG_S_OP1: begin
        if (rvalid_i) begin
          if (rdata_i == oag_pkg::OAG_PREFIX_OP && !cur_ff.pre) begin
            nxt_ff.pre = 1'b1;
            nxt_ff.rd = 1'b1;
            nxt_ff.maddr = 16'(cur_ff.pc + 16'h0001);
          end else begin
            nxt_ff.op = rdata_i;
            nxt_ff.st = oag_pkg::OAG_S_OP2;
          end
        end else begin
          nxt_ff.rd = 1'b1;
        end
      end
      oag_pkg::OAG_S_OP2: begin
        // operand bytes follow the opcode
        if (cur_ff.cnt == dnb) begin
          if (dmode == oag_pkg::OAG_M_ABS_IND ||
              dmode == oag_pkg::OAG_M_REL_IND ||
              dmode == oag_pkg::OAG_M_ABS_OFF ||
              dmode == oag_pkg::OAG_M_REL_OFF ||
              dmode == oag_pkg::OAG_M_ABS_IDX ||
              dmode == oag_pkg::OAG_M_REL_IDX) begin
            nxt_ff.st = oag_pkg::OAG_S_RD0;
            nxt_ff.rd = 1'b1;
            // index register or pointer low byte first
            nxt_ff.maddr = (dmode == oag_pkg::OAG_M_ABS_IDX ||
              dmode == oag_pkg::OAG_M_REL_IDX) ?
              {8'h00, oag_pkg::OAG_REG_B} :
              {8'h00, pair_lo_ad};
          end else begin
            nxt_ff.st = oag_pkg::OAG_S_DONE;
          end
        end else if (rvalid_i) begin
          // answer first: the request stands until it is answered
          if (cur_ff.cnt == 2'h0) begin
            nxt_ff.b1 = rdata_i;
          end else begin
            nxt_ff.b2 = rdata_i;
          end
          nxt_ff.cnt = 2'(cur_ff.cnt + 2'h1);
        end else if (cur_ff.rd) begin
          nxt_ff.rd = 1'b1;
        end else begin
          nxt_ff.rd = 1'b1;
          nxt_ff.maddr = 16'(cur_ff.pc + 16'(cur_ff.pre) +
            16'(cur_ff.cnt) + 16'h0001);
        end
      end
      oag_pkg::OAG_S_RD0: begin
        if (rvalid_i) begin
          if (dmode == oag_pkg::OAG_M_ABS_IDX ||
              dmode == oag_pkg::OAG_M_REL_IDX) begin
            nxt_ff.regb = rdata_i;
            nxt_ff.st = oag_pkg::OAG_S_DONE;
          end else begin
            nxt_ff.pl = rdata_i;
            nxt_ff.rd = 1'b1;
            nxt_ff.maddr = {8'h00, 8'(pair_lo_ad - 8'h01)};
            nxt_ff.st = oag_pkg::OAG_S_RD1;
          end
        end else begin
          nxt_ff.rd = 1'b1;
        end
      end
      oag_pkg::OAG_S_RD1: begin
        if (rvalid_i) begin
          nxt_ff.ph = rdata_i; // high byte from register below
          nxt_ff.st = oag_pkg::OAG_S_DONE;
        end else begin
          nxt_ff.rd = 1'b1;
        end
      end
      oag_pkg::OAG_S_DONE: begin
        // publish the resolved operand addresses
        nxt_ff.done = 1'b1;
        nxt_ff.mode = dmode;
        nxt_ff.bad = (dmode == oag_pkg::OAG_M_BAD);
        nxt_ff.nia = nia;
        nxt_ff.immv = 1'b0;
        nxt_ff.pcl = 1'b0;
        nxt_ff.rferr = 1'b0;
        nxt_ff.src = 16'h0000;
        // destination also read as the second input
        nxt_ff.dst = dsta ? {8'h00, oag_pkg::OAG_REG_A} :
          dstb ? {8'h00, oag_pkg::OAG_REG_B} :
          {8'h00, (dnb == 2'h2) ? cur_ff.b2 : cur_ff.b1};
        nxt_ff.rfc = oag_pkg::OAG_RF_CYC_GEN;
        case (dmode)
          oag_pkg::OAG_M_REG: nxt_ff.src = {8'h00, cur_ff.b1};
          oag_pkg::OAG_M_IMPLIED: nxt_ff.src = {8'h00, oag_pkg::OAG_REG_B};
          oag_pkg::OAG_M_PERIPH:
            nxt_ff.src = {oag_pkg::OAG_PERIPH_HI, cur_ff.b1};
          oag_pkg::OAG_M_IMMED: begin
            nxt_ff.imm = cur_ff.b1;
            nxt_ff.immv = 1'b1;
          end
          oag_pkg::OAG_M_PCREL: begin
            nxt_ff.pcl = 1'b1;
            nxt_ff.npc = sum;
          end
          oag_pkg::OAG_M_SPREL: begin
            nxt_ff.src = {8'h00, sum[7:0]};
            nxt_ff.dst = {8'h00, oag_pkg::OAG_REG_A};
          end
          oag_pkg::OAG_M_ABS_DIR: nxt_ff.src = {cur_ff.b1, cur_ff.b2};
          oag_pkg::OAG_M_REL_DIR, oag_pkg::OAG_M_REL_IDX,
          oag_pkg::OAG_M_REL_IND, oag_pkg::OAG_M_REL_OFF: begin
            nxt_ff.pcl = 1'b1;
            nxt_ff.npc = sum;
          end
          oag_pkg::OAG_M_BAD: nxt_ff.src = 16'h0000;
          default: nxt_ff.src = sum; // absolute extended forms
        endcase
        // extended class reaching the register file costs two cycles
        // jumps load the program counter and reach no data
        if (dmode >= oag_pkg::OAG_M_ABS_DIR && dmode != oag_pkg::OAG_M_BAD
            && !nxt_ff.pcl && nxt_ff.src[15:8] == 8'h00) begin
          nxt_ff.rfc = oag_pkg::OAG_RF_CYC_EXT;
        end
        // general mode outside the implemented file
        if ((dmode == oag_pkg::OAG_M_REG || dmode == oag_pkg::OAG_M_SPREL) &&
            !RF_LARGE && nxt_ff.src[7]) begin
          nxt_ff.rferr = 1'b1;
        end
        nxt_ff.st = oag_pkg::OAG_S_IDLE;
      end
      default: nxt_ff.st = oag_pkg::OAG_S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
      cur_ff.sp <= oag_pkg::OAG_SP_RESET;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from the state register
  assign mem_rd_o = cur_ff.rd;
  assign mem_addr_o = cur_ff.maddr;
  assign done_o = cur_ff.done;
  assign bad_op_o = cur_ff.bad;
  assign src_addr_o = cur_ff.src;
  assign dst_addr_o = cur_ff.dst;
  assign imm_o = cur_ff.imm;
  assign imm_valid_o = cur_ff.immv;
  assign pc_load_o = cur_ff.pcl;
  assign new_pc_o = cur_ff.npc;
  assign next_instruction_address_o = cur_ff.nia;
  assign rf_cycles_o = cur_ff.rfc;
  assign rf_range_err_o = cur_ff.rferr;
  assign mode_o = cur_ff.mode;
endmodule
`default_nettype wire

// *** verilog/oag_pkg.sv ***
// shared constants and types for the operand address generator
package oag_pkg;
  // addressing modes, fourteen in two classes
  typedef enum logic [3:0] {
    OAG_M_IMPLIED = 4'h0,
    OAG_M_REG     = 4'h1,
    OAG_M_PERIPH  = 4'h2,
    OAG_M_IMMED   = 4'h3,
    OAG_M_PCREL   = 4'h4,
    OAG_M_SPREL   = 4'h5,
    OAG_M_ABS_DIR = 4'h6,
    OAG_M_ABS_IDX = 4'h7,
    OAG_M_ABS_IND = 4'h8,
    OAG_M_ABS_OFF = 4'h9,
    OAG_M_REL_DIR = 4'hA,
    OAG_M_REL_IDX = 4'hB,
    OAG_M_REL_IND = 4'hC,
    OAG_M_REL_OFF = 4'hD,
    OAG_M_BAD     = 4'hF
  } oag_mode_t;
  // operation class of a decoded opcode
  typedef enum logic [2:0] {
    OAG_C_OTHER = 3'h0,
    OAG_C_CMP   = 3'h1,
    OAG_C_MOV   = 3'h2,
    OAG_C_LONG_RELATIVE_JUMP_OP  = 3'h3,
    OAG_C_CALL  = 3'h4,
    OAG_C_ALU   = 3'h5
  } oag_class_t;
  // sequencer states, gray along fetch path
  typedef enum logic [2:0] {
    OAG_S_IDLE = 3'b000,
    OAG_S_OP1  = 3'b001,
    OAG_S_OP2  = 3'b011,
    OAG_S_RD0  = 3'b010,
    OAG_S_RD1  = 3'b110,
    OAG_S_DONE = 3'b111
  } oag_state_t;
  localparam logic [7:0] OAG_PREFIX_OP = 8'hF4;
  localparam logic [7:0] OAG_PERIPH_HI = 8'h10;
  localparam logic [7:0] OAG_REG_A = 8'h00;
  localparam logic [7:0] OAG_REG_B = 8'h01;
  localparam logic [8:0] OAG_RF_SIZE_SMALL = 9'h080;
  localparam logic [8:0] OAG_RF_SIZE_LARGE = 9'h100;
  localparam int OAG_INSTR_TYPES = 73;
  localparam int OAG_OPCODES = 246;
  localparam logic [1:0] OAG_RF_CYC_GEN = 2'h1;
  localparam logic [1:0] OAG_RF_CYC_EXT = 2'h2;
  localparam logic [7:0] OAG_SP_RESET = 8'h01;
endpackage

// *** verilog/oag_decode.sv ***
// opcode decoder: mode, class and operand byte count
`timescale 1ns/10ps
`default_nettype none
module oag_decode (
  // opcode bytes
  input wire logic [7:0] op_i,
  input wire logic prefixed_i,
  // decoded fields
  output oag_pkg::oag_mode_t mode_o,
  output oag_pkg::oag_class_t cls_o,
  output logic [1:0] nbytes_o,
  output logic dst_a_o,
  output logic dst_b_o
);
  // low nibble picks the instruction, high nibble the mode
  always_comb begin
    mode_o = oag_pkg::OAG_M_BAD;
    cls_o = oag_pkg::OAG_C_OTHER;
    nbytes_o = 2'h0;
    dst_a_o = 1'b0;
    dst_b_o = 1'b0;
    case (op_i[3:0])
      4'hD: cls_o = oag_pkg::OAG_C_CMP;
      4'hA: cls_o = oag_pkg::OAG_C_MOV;
      4'h9: cls_o = oag_pkg::OAG_C_LONG_RELATIVE_JUMP_OP;
      4'hE: cls_o = oag_pkg::OAG_C_CALL;
      4'h8: cls_o = oag_pkg::OAG_C_ALU;
      default: cls_o = oag_pkg::OAG_C_OTHER;
    endcase
    if (prefixed_i) begin // two-byte opcodes
      if (op_i[7:4] == 4'hE) begin
        mode_o = (op_i[3:0] == 4'h9 || op_i[3:0] == 4'hF) ?
          oag_pkg::OAG_M_REL_OFF : oag_pkg::OAG_M_ABS_OFF;
        nbytes_o = 2'h2;
        dst_a_o = 1'b1;
      end
    end else begin
      case (op_i[7:4])
        4'h1: begin mode_o = oag_pkg::OAG_M_REG; nbytes_o = 2'h1;
          dst_a_o = 1'b1; end
        4'h2: begin mode_o = oag_pkg::OAG_M_IMMED; nbytes_o = 2'h1;
          dst_a_o = 1'b1; end
        4'h3: begin mode_o = oag_pkg::OAG_M_REG; nbytes_o = 2'h1;
          dst_b_o = 1'b1; end
        4'h4: begin mode_o = oag_pkg::OAG_M_REG; nbytes_o = 2'h2; end
        4'h5: begin mode_o = oag_pkg::OAG_M_IMMED; nbytes_o = 2'h1;
          dst_b_o = 1'b1; end
        4'h6: begin mode_o = oag_pkg::OAG_M_IMPLIED;
          dst_a_o = 1'b1; end
        4'h7: begin mode_o = oag_pkg::OAG_M_IMMED; nbytes_o = 2'h2; end
        4'h8: begin mode_o = (cls_o == oag_pkg::OAG_C_LONG_RELATIVE_JUMP_OP) ?
          oag_pkg::OAG_M_REL_DIR : oag_pkg::OAG_M_ABS_DIR;
          nbytes_o = 2'h2; dst_a_o = 1'b1; end
        4'h9: begin mode_o = (cls_o == oag_pkg::OAG_C_LONG_RELATIVE_JUMP_OP) ?
          oag_pkg::OAG_M_REL_IND : oag_pkg::OAG_M_ABS_IND;
          nbytes_o = 2'h1; dst_a_o = 1'b1; end
        4'hA: begin mode_o = (cls_o == oag_pkg::OAG_C_LONG_RELATIVE_JUMP_OP) ?
          oag_pkg::OAG_M_REL_IDX : oag_pkg::OAG_M_ABS_IDX;
          nbytes_o = 2'h2; dst_a_o = 1'b1; end
        4'hB: begin mode_o = oag_pkg::OAG_M_PERIPH; nbytes_o = 2'h1;
          dst_a_o = 1'b1; end
        4'h0: begin mode_o = oag_pkg::OAG_M_PCREL; nbytes_o = 2'h1; end
        4'hF: begin // stack-relative only for compare and move
          if (op_i[3:0] == 4'h3 || op_i[3:0] == 4'h2) begin
            mode_o = oag_pkg::OAG_M_SPREL;
            cls_o = (op_i[3:0] == 4'h3) ? oag_pkg::OAG_C_CMP :
              oag_pkg::OAG_C_MOV;
            nbytes_o = 2'h1;
            dst_a_o = 1'b1;
          end
        end
        default: mode_o = oag_pkg::OAG_M_BAD;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verilog/oag_adder.sv ***
// 16-bit three-term address adder with wrap
`timescale 1ns/10ps
`default_nettype none
module oag_adder #(
  parameter int WIDTH = 16
) (
  // terms
  input wire logic [WIDTH-1:0] a_i,
  input wire logic [WIDTH-1:0] b_i,
  input wire logic [WIDTH-1:0] c_i,
  // wrapped sum
  output logic [WIDTH-1:0] sum_o
);
  // carry out is dropped, no flag is raised
  assign sum_o = WIDTH'(a_i + b_i + c_i);
endmodule
`default_nettype wire

// *** bench/oag_mem_model.sv ***
// internal memory bus model: byte memory with adjustable answer delay
`timescale 1ns/10ps
`default_nettype none
module oag_mem_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // read request
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  // read answer
  output var logic [7:0] rdata_o,
  output var logic rvalid_o
);
  logic [7:0] mem [0:65535];
  int lat = 0;
  int cnt;
  logic busy;
  logic [15:0] addr;
  // background pattern so stale bytes never look right
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
  end
  // take a request, wait lat cycles, pulse the answer once
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 8'h00;
      cnt <= 0;
      addr <= 16'h0000;
    end else begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o; // no stable data between answers
      if (busy) begin
        if (cnt == 0) begin
          rvalid_o <= 1'b1;
          rdata_o <= mem[addr];
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 1;
        end
      end else if (mem_rd_i && !rvalid_o) begin
        busy <= 1'b1;
        addr <= mem_addr_i;
        cnt <= lat;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/oag_core_sva.sv ***
// assertion checker for the operand address generator ports
`timescale 1ns/10ps
`default_nettype none
module oag_core_sva #(
  parameter bit RF_LARGE = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // results
  input wire logic done_o,
  input wire logic bad_op_o,
  input wire logic [15:0] src_addr_o,
  input wire logic [15:0] dst_addr_o,
  input wire logic imm_valid_o,
  input wire logic pc_load_o,
  input wire logic [15:0] new_pc_o,
  input wire logic [1:0] rf_cycles_o,
  input wire logic rf_range_err_o,
  input wire logic [3:0] mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // completion and holding of results
  AST_DONE_ONE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_HOLD: assert property (!done_o |-> $stable(src_addr_o) &&
    $stable(new_pc_o) && $stable(mode_o) && $stable(dst_addr_o))
    else $error("results moved between completions");
  AST_MODE_LEGAL: assert property (done_o && !bad_op_o |-> mode_o <= 4'hD)
    else $error("illegal mode code");
  AST_RANGE_OK: assert property (done_o && RF_LARGE |-> !rf_range_err_o)
    else $error("range error on large register file");
  // stack relative results
  AST_SPREL_ADDR: assert property (done_o && mode_o == oag_pkg::OAG_M_SPREL
    |-> src_addr_o[15:8] == 8'h00 && !bad_op_o)
    else $error("stack relative address outside page zero");
  AST_SPREL_ACC: assert property (done_o && mode_o == oag_pkg::OAG_M_SPREL
    |-> dst_addr_o == 16'h0000)
    else $error("stack relative second operand not accumulator");
  // register file access cycles
  AST_REG_ONE: assert property (done_o && mode_o == oag_pkg::OAG_M_REG
    |-> src_addr_o[15:8] == 8'h00 && rf_cycles_o == 2'h1)
    else $error("register mode not one cycle");
  AST_EXT_TWO: assert property (done_o && mode_o inside {4'h6, 4'h7, 4'h8,
    4'h9} && src_addr_o[15:8] == 8'h00 |-> rf_cycles_o == 2'h2)
    else $error("extended register access not two cycles");
  // jumps and immediates
  AST_JUMP_REL: assert property (done_o && pc_load_o
    |-> mode_o inside {4'h4, 4'hA, 4'hB, 4'hC, 4'hD})
    else $error("jump from non relative mode");
  AST_IMM_MODE: assert property (done_o && imm_valid_o
    |-> mode_o == oag_pkg::OAG_M_IMMED)
    else $error("immediate flag outside immediate mode");
  // main scenarios
  COV_SPREL: cover property (done_o && mode_o == oag_pkg::OAG_M_SPREL);
  COV_JUMP: cover property (done_o && pc_load_o);
  COV_IMM: cover property (done_o && imm_valid_o);
  COV_REG: cover property (done_o && mode_o == oag_pkg::OAG_M_REG);
endmodule
bind oag_core oag_core_sva #(.RF_LARGE(RF_LARGE)) u_sva (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .done_o(done_o), .bad_op_o(bad_op_o),
  .src_addr_o(src_addr_o), .dst_addr_o(dst_addr_o),
  .imm_valid_o(imm_valid_o), .pc_load_o(pc_load_o), .new_pc_o(new_pc_o),
  .rf_cycles_o(rf_cycles_o), .rf_range_err_o(rf_range_err_o),
  .mode_o(mode_o));
`default_nettype wire

// *** bench/test_operand_address_generator.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_operand_address_generator;
  typedef struct {
    logic [15:0] pc; logic [7:0] sp; logic [31:0] code;
    oag_pkg::oag_mode_t mode; logic [1:0] kind; logic [15:0] val;
    logic [2:0] ln; logic [1:0] rfc;
  } oag_tb_row_t;
  // kind 0 source address, 1 jump target, 2 immediate
  oag_tb_row_t rows [0:14] = '{
    '{16'h7000, 8'h00, 32'h8D123400, oag_pkg::OAG_M_ABS_DIR, 0, 16'h1234, 3, 0},
    '{16'h7010, 8'h00, 32'h89010000, oag_pkg::OAG_M_REL_DIR, 1, 16'h7113, 3, 0},
    '{16'h7020, 8'h00, 32'h9D210000, oag_pkg::OAG_M_ABS_IND, 0, 16'h1234, 2, 0},
    '{16'h7030, 8'h00, 32'h99210000, oag_pkg::OAG_M_REL_IND, 1, 16'h8266, 2, 0},
    '{16'h7040, 8'h00, 32'hA9FFF000, oag_pkg::OAG_M_REL_IDX, 1, 16'h7038, 3, 0},
    '{16'h7050, 8'h00, 32'hAD100000, oag_pkg::OAG_M_ABS_IDX, 0, 16'h1005, 3, 0},
    '{16'h7060, 8'hFE, 32'hF3050000, oag_pkg::OAG_M_SPREL, 0, 16'h0003, 2, 1},
    '{16'h7070, 8'h02, 32'hF2FC0000, oag_pkg::OAG_M_SPREL, 0, 16'h00FE, 2, 1},
    '{16'h7080, 8'h00, 32'h2D5A0000, oag_pkg::OAG_M_IMMED, 2, 16'h005A, 2, 0},
    '{16'h7090, 8'h00, 32'h1D210000, oag_pkg::OAG_M_REG, 0, 16'h0021, 2, 1},
    '{16'h70A0, 8'h00, 32'hF4E9FE21, oag_pkg::OAG_M_REL_OFF, 1, 16'h82D6, 4, 0},
    '{16'h70B0, 8'h00, 32'hF4ED0221, oag_pkg::OAG_M_ABS_OFF, 0, 16'h1236, 4, 0},
    '{16'h70C0, 8'h00, 32'h8D002100, oag_pkg::OAG_M_ABS_DIR, 0, 16'h0021, 3, 2},
    '{16'h70D0, 8'h00, 32'h00030000, oag_pkg::OAG_M_PCREL, 1, 16'h70D5, 2, 0},
    '{16'h70E0, 8'h00, 32'hBA250000, oag_pkg::OAG_M_PERIPH, 0, 16'h1025, 2, 1}
  };
  logic mclk_i, rst_n_i, start_i, rvalid_i, mem_rd_o, done_o, bad_op_o;
  logic imm_valid_o, pc_load_o, rf_range_err_o;
  logic [15:0] pc_i, mem_addr_o, src_addr_o, dst_addr_o, new_pc_o, nia_o;
  logic [7:0] sp_i, rdata_i, imm_o;
  logic [1:0] rf_cycles_o;
  logic [3:0] mode_o;
  int fail_count = 0;
  int n_tests = 0;
  // design and memory partner
  oag_core #(.RF_LARGE(1'b1)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .pc_i(pc_i), .stack_pointer_reg_i(sp_i),
    .rdata_i(rdata_i), .rvalid_i(rvalid_i), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .done_o(done_o), .bad_op_o(bad_op_o),
    .src_addr_o(src_addr_o), .dst_addr_o(dst_addr_o), .imm_o(imm_o),
    .imm_valid_o(imm_valid_o), .pc_load_o(pc_load_o), .new_pc_o(new_pc_o),
    .next_instruction_address_o(nia_o), .rf_cycles_o(rf_cycles_o),
    .rf_range_err_o(rf_range_err_o), .mode_o(mode_o));
  oag_mem_model u_mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .rdata_o(rdata_i),
    .rvalid_o(rvalid_i));
  // clock at 5 ns
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for the completion pulse
  task automatic wait_done();
    for (int t = 0; t < 200; t++) begin
      @(posedge mclk_i);
      #1;
      if (done_o === 1'b1) return;
    end
    `CHK("done", 1'b1, 1'b0)
    print_verdict();
  endtask
  task automatic launch(input int i);
    @(posedge mclk_i);
    start_i <= 1'b1;
    pc_i <= rows[i].pc;
    sp_i <= rows[i].sp;
    @(posedge mclk_i);
    start_i <= 1'b0;
  endtask
  task automatic check_row(input int i);
    `CHK("mode", rows[i].mode, mode_o)
    `CHK("nia", rows[i].pc + 16'(rows[i].ln), nia_o)
    `CHK("bad_op", 1'b0, bad_op_o)
    `CHK("pc_load", rows[i].kind == 1, pc_load_o)
    if (rows[i].kind == 1) `CHK("new_pc", rows[i].val, new_pc_o)
    if (rows[i].kind == 0) `CHK("src", rows[i].val, src_addr_o)
    if (rows[i].kind == 2) `CHK("imm", rows[i].val[7:0], imm_o)
    if (rows[i].kind == 2) `CHK("imm_valid", 1'b1, imm_valid_o)
    if (rows[i].kind != 1) `CHK("dst", 16'h0000, dst_addr_o)
    if (rows[i].rfc != 0) `CHK("rf_cyc", rows[i].rfc, rf_cycles_o)
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    print_verdict();
  end
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    pc_i = 16'h0000;
    sp_i = 8'h00;
    #1;
    // program bytes, pointer pair and index register
    for (int i = 0; i < 15; i++) begin
      for (int b = 0; b < 4; b++) begin
        u_mem.mem[rows[i].pc + 16'(b)] = rows[i].code[31 - 8 * b -: 8];
      end
    end
    u_mem.mem[16'h0020] = 8'h12;
    u_mem.mem[16'h0021] = 8'h34;
    u_mem.mem[16'h0001] = 8'h05;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    `CHK("rst_done", 1'b0, done_o)
    `CHK("rst_mode", 4'h0, mode_o)
    `CHK("rst_rd", 1'b0, mem_rd_o)
    // table, prompt and slow memory
    for (int l = 0; l < 2; l++) begin
      u_mem.lat = 2 * l;
      for (int i = 0; i < 15; i++) begin
        launch(i);
        wait_done();
        check_row(i);
      end
    end
    // start held through a busy instruction, then taken at done
    @(posedge mclk_i);
    start_i <= 1'b1;
    pc_i <= rows[0].pc;
    sp_i <= 8'h00;
    @(posedge mclk_i);
    pc_i <= rows[2].pc;
    wait_done();
    check_row(0);
    @(posedge mclk_i);
    start_i <= 1'b0;
    wait_done();
    check_row(2);
    // reset in mid instruction, then recover
    launch(4);
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("mid_done", 1'b0, done_o)
    `CHK("mid_pc", 16'h0000, new_pc_o)
    `CHK("mid_rd", 1'b0, mem_rd_o)
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    launch(10);
    wait_done();
    check_row(10);
    print_verdict();
  end
endmodule
`default_nettype wire
